// >>> mtx_pkg.sv
// Purpose: Shared constants for the transfer and arithmetic execution datapath
// Assumes: 8-bit data, 16-bit counter, one instruction issued per request
// Notes:   Operation codes are a local encoding presented by the decoder
package mtx_pkg;

    // Operation selector presented with each instruction
    typedef enum logic [4:0] {
        MTX_OP_NOP       = 5'h00,
        MTX_OP_LDI       = 5'h01,  // Immediate into working register
        MTX_OP_STM       = 5'h02,  // Working register into memory
        MTX_OP_LDM       = 5'h03,  // Memory into working register
        MTX_OP_LDIO      = 5'h04,  // IO register into working register
        MTX_OP_STIO      = 5'h05,  // Working register into IO register
        MTX_OP_CNT_RD    = 5'h06,  // Counter into memory word
        MTX_OP_CNT_WR    = 5'h07,  // Memory word into counter
        MTX_OP_IDX_LD    = 5'h08,  // Indirect load
        MTX_OP_IDX_ST    = 5'h09,  // Indirect store
        MTX_OP_XCH       = 5'h0A,  // Exchange with memory
        MTX_OP_SAVE      = 5'h0B,  // Context save
        MTX_OP_RESTORE   = 5'h0C,  // Context restore
        MTX_OP_ADD_AI    = 5'h0D,
        MTX_OP_ADD_AM    = 5'h0E,
        MTX_OP_ADD_MA    = 5'h0F,
        MTX_OP_ADDC_AM   = 5'h10,
        MTX_OP_ADDC_MA   = 5'h11,
        MTX_OP_ADDC_A    = 5'h12,
        MTX_OP_ADDC_M    = 5'h13,
        MTX_OP_SUB_AI    = 5'h14,
        MTX_OP_SUB_AM    = 5'h15,
        MTX_OP_SUB_MA    = 5'h16
    } mtx_op_t;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        MTX_ST_IDLE  = 4'h1,
        MTX_ST_PTR   = 4'h2,  // Pointer word arrives
        MTX_ST_DATA  = 4'h4,  // Indirect load data arrives
        MTX_ST_WRITE = 4'h8   // Indirect store third cycle
    } mtx_state_t;

    // Condition register layout and reset values
    localparam int          MTX_FLAG_NULL   = 0;
    localparam int          MTX_FLAG_BORROW = 1;
    localparam int          MTX_FLAG_HALF   = 2;
    localparam int          MTX_FLAG_RANGE  = 3;
    localparam logic [3:0]  MTX_FLAG_UPPER  = 4'hF;
    localparam logic [3:0]  MTX_FLAG_RESET  = 4'h0;
    localparam logic [7:0]  MTX_ACC_RESET   = 8'h00;
    localparam logic [7:0]  MTX_SP_RESET    = 8'h00;
    localparam logic [15:0] MTX_CNT_RESET   = 16'h0000;

    // Operand address limits and stack step
    localparam logic [7:0]  MTX_WORD_LIMIT  = 8'h1F;
    localparam logic [7:0]  MTX_BIT_LIMIT   = 8'h0F;
    localparam logic [7:0]  MTX_SP_STEP     = 8'h02;

endpackage : mtx_pkg

// >>> mtx_exec.sv
// Purpose: Execution datapath for data transfer and add/subtract instructions
// Assumes: Memory reads answer in the same cycle as the registered read strobe
// Notes:   Every output except busy comes from a flip-flop; memory word = two bytes, low first
`timescale 1ns/1ns

// Behaviour
// - Null bit set when result is zero
// - Borrow bit is carry or unsigned borrow
// - Half bit is low nibble carry or borrow
// - Range bit flags signed overflow
// - Word operands only at addresses 0..0x1F
// - Bit operands only at addresses 0..0xF (not checked in this block)
// - Immediate load keeps all condition bits
// - Stores copy value, flags untouched
// - Memory and IO loads update null bit only; indirect load keeps all bits
// - Counter read writes count to word
// - Counter write loads count from word
// - Indirect load fetches through pointer word
// - Indirect store takes three cycles
// - Exchange swaps register and memory byte
// - Save writes pair, stack up two
// - Restore: stack down two, reload pair
// - Add updates all four bits
// - Add with carry sums three terms
// - Single operand add adds carry only
// - Subtract adds two's complement operand
// - Memory minus register back to memory
// - Flag layout, upper nibble reads ones
module mtx_exec (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            op_valid,      // Instruction present this cycle
    input  wire mtx_pkg::mtx_op_t op_code,      // Operation selector
    input  wire logic [7:0]      op_addr,       // Memory or IO operand address
    input  wire logic [7:0]      op_imm,        // Immediate operand
    input  wire logic [7:0]      mem_rdata,     // Memory read data, cycle after read
    input  wire logic [15:0]     mem_wrdata_w,  // Word operand read data (low byte low)
    input  wire logic [7:0]      io_rdata,      // IO read data, same cycle as address
    input  wire logic [7:0]      sp_wdata,      // Software write value for the stack index
    input  wire logic            sp_we,         // Software write of the stack index
    output logic                 busy,          // Sequencer holds off further issue
    output logic                 op_done,       // Instruction retired pulse
    output logic                 addr_err,      // Word operand outside allowed range
    output logic [7:0]           mem_addr,      // Memory address
    output logic                 mem_rd,        // Memory read strobe
    output logic                 mem_wr,        // Memory write strobe (byte)
    output logic                 mem_wr2,       // Memory pair write strobe (two bytes)
    output logic [15:0]          mem_wdata,     // Write data, low byte first
    output logic [7:0]           io_addr,       // IO register address
    output logic                 io_wr,         // IO write strobe
    output logic [7:0]           io_wdata,      // IO write data
    output logic [7:0]           working_register,
    output logic [7:0]           flag_reg,      // Condition register view
    output logic [7:0]           stack_top_index,
    output logic [15:0]          sixteen_bit_counter
);
    import mtx_pkg::*;

    // Architectural state
    logic [7:0]  acc_q;           // Working register
    logic [3:0]  flg_q;           // Condition bits
    logic [7:0]  sp_q;            // Stack index
    logic [15:0] cnt_q;           // Counter image
    mtx_state_t  st_q;            // Sequencer for indirect moves
    mtx_op_t     pend_op_q;       // Operation awaiting memory data
    logic [7:0]  pend_addr_q;     // Its operand address
    logic        pend_q;          // One-cycle operation waiting on memory data
    logic [7:0]  ptr_q;           // Indirect target captured from pointer word

    // Operand decoding
    wire logic is_word   = op_code == MTX_OP_CNT_RD || op_code == MTX_OP_CNT_WR
                        || op_code == MTX_OP_IDX_LD || op_code == MTX_OP_IDX_ST;
    wire logic word_bad  = op_valid && is_word && (op_addr > MTX_WORD_LIMIT);
    wire logic issue     = op_valid && !busy && !word_bad;
    wire logic mem_src   = op_code inside {MTX_OP_LDM, MTX_OP_XCH, MTX_OP_ADD_AM, MTX_OP_ADD_MA,
                                           MTX_OP_ADDC_AM, MTX_OP_ADDC_MA, MTX_OP_ADDC_M,
                                           MTX_OP_SUB_AM, MTX_OP_SUB_MA, MTX_OP_RESTORE, MTX_OP_CNT_WR};

    // ALU, evaluated in the cycle the memory data arrive (or at issue for immediate forms)
    mtx_op_t     alu_op;
    logic [7:0]  alu_a;
    logic [7:0]  alu_b;
    logic        alu_cin;
    logic        alu_sub;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [7:0]  res;
    logic        c_out;
    logic        h_out;
    logic        v_out;

    assign alu_op = pend_q ? pend_op_q : op_code;

    // Operand choice; subtraction feeds the inverted subtrahend with carry in of one
    always_comb
    begin
        alu_a   = acc_q;
        alu_b   = pend_q ? mem_rdata : op_imm;
        alu_cin = 1'b0;
        alu_sub = 1'b0;
        case (alu_op)
            MTX_OP_ADDC_AM, MTX_OP_ADDC_MA:
            begin
                alu_cin = flg_q[MTX_FLAG_BORROW];
            end
            MTX_OP_ADDC_A:
            begin
                alu_b   = 8'h00;
                alu_cin = flg_q[MTX_FLAG_BORROW];
            end
            MTX_OP_ADDC_M:
            begin
                alu_a   = mem_rdata;
                alu_b   = 8'h00;
                alu_cin = flg_q[MTX_FLAG_BORROW];
            end
            MTX_OP_SUB_AI, MTX_OP_SUB_AM:
            begin
                alu_b   = ~alu_b;
                alu_cin = 1'b1;
                alu_sub = 1'b1;
            end
            MTX_OP_SUB_MA:
            begin
                alu_a   = mem_rdata;
                alu_b   = ~acc_q;
                alu_cin = 1'b1;
                alu_sub = 1'b1;
            end
            default:
            begin
                alu_sub = 1'b0;
            end
        endcase
    end

    // Sum with carries from bit 3 and bit 7; borrow is the inverted carry on subtraction
    assign sum9  = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
    assign sum5  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
    assign res   = sum9[7:0];
    assign c_out = sum9[8] ^ alu_sub;
    assign h_out = sum5[4] ^ alu_sub;
    assign v_out = (alu_a[7] == alu_b[7]) && (res[7] != alu_a[7]);

    // All four bits from the arithmetic result
    wire logic [3:0] arith_flags = {v_out, h_out, c_out, res == 8'h00};

    // Next state of the working register and condition bits
    logic [7:0] acc_d;
    logic [3:0] flg_d;
    always_comb
    begin
        acc_d = acc_q;
        flg_d = flg_q;
        if (issue && op_code == MTX_OP_LDI)
        begin
            acc_d = op_imm;
        end
        else if (issue && op_code inside {MTX_OP_ADD_AI, MTX_OP_SUB_AI})
        begin
            acc_d = res;
            flg_d = arith_flags;
        end
        else if (issue && op_code == MTX_OP_ADDC_A)
        begin
            acc_d = res;
            flg_d = arith_flags;
        end
        else if (issue && op_code == MTX_OP_LDIO)
        begin
            acc_d = io_rdata;
            flg_d[MTX_FLAG_NULL] = io_rdata == 8'h00;
        end
        else if (pend_q)
        begin
            case (pend_op_q)
                MTX_OP_LDM:
                begin
                    acc_d = mem_rdata;
                    flg_d[MTX_FLAG_NULL] = mem_rdata == 8'h00;
                end
                MTX_OP_XCH:
                begin
                    acc_d = mem_rdata;
                end
                MTX_OP_RESTORE:
                begin
                    acc_d = mem_wrdata_w[7:0];
                    flg_d = mem_wrdata_w[11:8];
                end
                MTX_OP_ADD_AM, MTX_OP_ADDC_AM, MTX_OP_SUB_AM:
                begin
                    acc_d = res;
                    flg_d = arith_flags;
                end
                MTX_OP_ADD_MA, MTX_OP_ADDC_MA, MTX_OP_ADDC_M, MTX_OP_SUB_MA:
                begin
                    flg_d = arith_flags;
                end
                default:
                begin
                    acc_d = acc_q;
                end
            endcase
        end
        else if (st_q == MTX_ST_DATA)
        begin
            acc_d = mem_rdata;
        end
    end

    // Sequencer; indirect moves need the pointer word first, one-cycle forms complete directly
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= MTX_ST_IDLE;
        end
        else
        begin
            case (st_q)
                MTX_ST_IDLE:
                begin
                    if (issue && op_code inside {MTX_OP_IDX_LD, MTX_OP_IDX_ST})
                        st_q <= MTX_ST_PTR;
                end
                MTX_ST_PTR:
                begin
                    st_q <= (pend_op_q == MTX_OP_IDX_ST) ? MTX_ST_WRITE : MTX_ST_DATA;
                end
                default:
                begin
                    st_q <= MTX_ST_IDLE;
                end
            endcase
        end
    end

    // Architectural registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            acc_q       <= MTX_ACC_RESET;
            flg_q       <= MTX_FLAG_RESET;
            sp_q        <= MTX_SP_RESET;
            cnt_q       <= MTX_CNT_RESET;
            pend_q      <= 1'b0;
            pend_op_q   <= MTX_OP_NOP;
            pend_addr_q <= 8'h00;
            ptr_q       <= 8'h00;
        end
        else
        begin
            acc_q  <= acc_d;
            flg_q  <= flg_d;
            pend_q <= issue && mem_src;
            if (issue)
            begin
                pend_op_q   <= op_code;
                pend_addr_q <= op_addr;
            end
            if (st_q == MTX_ST_PTR)
                ptr_q <= mem_wrdata_w[7:0];     // High byte of a pointer word is dropped
            // Software write of the stack index wins; bit 0 is left to software
            if (sp_we)
                sp_q <= sp_wdata;
            else if (issue && op_code == MTX_OP_SAVE)
                sp_q <= sp_q + MTX_SP_STEP;
            else if (issue && op_code == MTX_OP_RESTORE)
                sp_q <= sp_q - MTX_SP_STEP;
            if (pend_q && pend_op_q == MTX_OP_CNT_WR)
                cnt_q <= mem_wrdata_w;
        end
    end

    // Bus outputs, all registered
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mem_addr  <= 8'h00;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_wr2   <= 1'b0;
            mem_wdata <= 16'h0000;
            io_addr   <= 8'h00;
            io_wr     <= 1'b0;
            io_wdata  <= 8'h00;
            op_done   <= 1'b0;
            addr_err  <= 1'b0;
        end
        else
        begin
            mem_rd   <= 1'b0;
            mem_wr   <= 1'b0;
            mem_wr2  <= 1'b0;
            io_wr    <= 1'b0;
            op_done  <= 1'b0;
            addr_err <= word_bad;
            io_addr  <= op_addr;
            if (issue)
            begin
                // Restore reads at the decreased index
                mem_addr <= (op_code == MTX_OP_RESTORE) ? sp_q - MTX_SP_STEP
                          : (op_code == MTX_OP_SAVE) ? sp_q : op_addr;
                mem_rd   <= mem_src || op_code inside {MTX_OP_CNT_WR, MTX_OP_IDX_LD, MTX_OP_IDX_ST};
                mem_wr   <= op_code == MTX_OP_STM;
                mem_wr2  <= op_code inside {MTX_OP_SAVE, MTX_OP_CNT_RD};
                mem_wdata <= (op_code == MTX_OP_SAVE) ? {MTX_FLAG_UPPER, flg_q, acc_q}
                           : (op_code == MTX_OP_CNT_RD) ? cnt_q : {8'h00, acc_q};
                io_wr    <= op_code == MTX_OP_STIO;
                io_wdata <= acc_q;
                op_done  <= !(mem_src || op_code inside {MTX_OP_CNT_WR, MTX_OP_IDX_LD, MTX_OP_IDX_ST});
            end
            else if (pend_q)
            begin
                // Memory-destination results and exchange write back the same address
                mem_addr  <= pend_addr_q;
                mem_wr    <= pend_op_q inside {MTX_OP_XCH, MTX_OP_ADD_MA, MTX_OP_ADDC_MA,
                                               MTX_OP_ADDC_M, MTX_OP_SUB_MA};
                mem_wdata <= {8'h00, (pend_op_q == MTX_OP_XCH) ? acc_q : res};
                op_done   <= 1'b1;
            end
            else if (st_q == MTX_ST_PTR)
            begin
                mem_addr <= mem_wrdata_w[7:0];
                mem_rd   <= pend_op_q == MTX_OP_IDX_LD;
                mem_wr   <= pend_op_q == MTX_OP_IDX_ST;
                mem_wdata <= {8'h00, acc_q};
            end
            else if (st_q == MTX_ST_DATA || st_q == MTX_ST_WRITE)
            begin
                op_done <= 1'b1;
            end
        end
    end

    // Memory-source operations occupy a second cycle waiting on read data
    assign busy             = pend_q || st_q != MTX_ST_IDLE;
    assign working_register = acc_q;
    assign flag_reg         = {MTX_FLAG_UPPER, flg_q};
    assign stack_top_index  = sp_q;
    assign sixteen_bit_counter = cnt_q;

    // Bit operands are outside this block; the limit is only held on an unused internal wire
    wire logic [7:0] bit_limit_unused = MTX_BIT_LIMIT;

    // Assertions
    upper_ones_a: assert property (@(posedge sys_clk) disable iff (rst)
        flag_reg[7:4] == 4'hF) else $error("upper flag bits not one");
    ldi_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        issue && op_code == MTX_OP_LDI |=> acc_q == $past(op_imm) && flg_q == $past(flg_q))
        else $error("immediate load wrong");
    save_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        issue && op_code == MTX_OP_SAVE && !sp_we |=> sp_q == $past(sp_q) + 8'h02)
        else $error("save step wrong");
    restore_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        issue && op_code == MTX_OP_RESTORE && !sp_we |=> sp_q == $past(sp_q) - 8'h02)
        else $error("restore step wrong");
    idx_two_a: assert property (@(posedge sys_clk) disable iff (rst)
        issue && op_code == MTX_OP_IDX_ST |=> ##1 mem_wr ##1 op_done)
        else $error("indirect store timing");
    word_range_a: assert property (@(posedge sys_clk) disable iff (rst)
        op_valid && is_word && op_addr > 8'h1F |=> addr_err && !mem_rd)
        else $error("word range not refused");
    zero_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        issue && op_code == MTX_OP_ADD_AI |=> flg_q[0] == (acc_q == 8'h00))
        else $error("null bit wrong");
    store_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
        issue && op_code inside {MTX_OP_STM, MTX_OP_STIO} |=> $stable(flg_q))
        else $error("store changed flags");
endmodule : mtx_exec

// >>> mtx_mem_model.sv
// Purpose: Data memory and IO partner for the exec datapath
// Assumes: Read data stand only in the cycle in which the registered mem_rd is high
// Notes:   Outside a read cycle the data are shown inverted, never held
`timescale 1ns/1ns
module mtx_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_wr2,
    input  wire logic [15:0] mem_wdata,
    output logic      [7:0]  mem_rdata,
    output logic      [15:0] mem_wrdata_w,
    input  wire logic [7:0]  op_addr,
    output logic      [7:0]  io_rdata,
    input  wire logic [7:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic [7:0]  io_wdata
);
    logic [7:0]  mem [0:255];   // Data bytes, preloaded by the bench
    logic [7:0]  io_q [0:255];  // IO registers
    wire  [15:0] rd_word = {mem[mem_addr + 8'h01], mem[mem_addr]};  // Low byte at lower address
    // Writes land at the edge after the strobe cycle
    always @(posedge sys_clk)
    begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata[7:0];
        if (mem_wr2)
        begin
            mem[mem_addr] <= mem_wdata[7:0];
            mem[mem_addr + 8'h01] <= mem_wdata[15:8];
        end
        if (io_wr)
            io_q[io_addr] <= io_wdata;
    end
    // The datapath samples read data at the end of the strobe cycle; inverted otherwise so a stray sample fails
    assign mem_rdata    = mem_rd ? rd_word[7:0] : ~rd_word[7:0];
    assign mem_wrdata_w = mem_rd ? rd_word : ~rd_word;
    assign io_rdata     = io_q[op_addr];
endmodule : mtx_mem_model

// >>> tb.sv
// Purpose: Self-checking bench for the exec datapath
// Assumes: One instruction in flight, issued after op_done
// Notes:   Expected values come from a local add model
`timescale 1ns/1ns
module tb;
    import mtx_pkg::*;
    logic        sys_clk, rst, op_valid, sp_we, busy, op_done, addr_err, mem_rd, mem_wr, mem_wr2, io_wr;
    mtx_op_t     op_code;
    logic [7:0]  op_addr, op_imm, mem_rdata, io_rdata, sp_wdata, mem_addr, io_addr, io_wdata;
    logic [7:0]  working_register, flag_reg, stack_top_index;
    logic [15:0] mem_wrdata_w, mem_wdata, sixteen_bit_counter;
    int          mismatches = 0, samples_checked = 0, cyc = 0, n;
    mtx_exec mtx_exec_inst (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .op_addr(op_addr), .op_imm(op_imm), .mem_rdata(mem_rdata), .mem_wrdata_w(mem_wrdata_w),
        .io_rdata(io_rdata), .sp_wdata(sp_wdata), .sp_we(sp_we), .busy(busy), .op_done(op_done),
        .addr_err(addr_err), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wr2(mem_wr2),
        .mem_wdata(mem_wdata), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
        .working_register(working_register), .flag_reg(flag_reg), .stack_top_index(stack_top_index),
        .sixteen_bit_counter(sixteen_bit_counter));
    mtx_mem_model mtx_mem_model_inst (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wr2(mem_wr2), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_wrdata_w(mem_wrdata_w), .op_addr(op_addr), .io_rdata(io_rdata), .io_addr(io_addr),
        .io_wr(io_wr), .io_wdata(io_wdata));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic test_done;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Returns {range, half, borrow, null, result}; subtract borrows are inverted carries
    function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic ci, input logic sub);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + 9'(sub | ci);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(sub | ci);
        return {(a[7] == bb[7]) && (s[7] != a[7]), h[4] ^ sub, s[8] ^ sub, s[7:0] == 8'h00, s[7:0]};
    endfunction : alu
    // One instruction, held until the taking edge; n counts cycles to op_done
    task automatic issue(input mtx_op_t op, input logic [7:0] a, input logic [7:0] imm);
        @(posedge sys_clk);
        op_code <= op;
        op_addr <= a;
        op_imm <= imm;
        op_valid <= 1'b1;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (op_done !== 1'b1 && n < 9);
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : issue
    task automatic t_move;
        issue(MTX_OP_LDI, 8'h00, 8'h01);
        issue(MTX_OP_ADD_AI, 8'h00, 8'h0F);
        chk(flag_reg, 8'hF4);
        issue(MTX_OP_LDI, 8'h00, 8'h00);
        chk(flag_reg, 8'hF4);
        issue(MTX_OP_LDI, 8'h00, 8'hA7);
        issue(MTX_OP_STM, 8'h31, 8'h00);
        chk(mtx_mem_model_inst.mem[8'h31], 8'hA7);
        mtx_mem_model_inst.mem[8'h33] = 8'h00;
        issue(MTX_OP_LDM, 8'h33, 8'h00);
        chk(flag_reg, 8'hF5);
        mtx_mem_model_inst.io_q[8'h10] = 8'h80;
        issue(MTX_OP_LDIO, 8'h10, 8'h00);
        chk(working_register, 8'h80);
        chk(flag_reg, 8'hF4);
        issue(MTX_OP_STIO, 8'h11, 8'h00);
        chk(mtx_mem_model_inst.io_q[8'h11], 8'h80);
        mtx_mem_model_inst.mem[8'h32] = 8'h99;
        issue(MTX_OP_XCH, 8'h32, 8'h00);
        chk(working_register, 8'h99);
        chk(mtx_mem_model_inst.mem[8'h32], 8'h80);
        chk(flag_reg, 8'hF4);
    endtask : t_move
    task automatic t_arith;
        mtx_op_t ops [10] = '{MTX_OP_ADD_AI, MTX_OP_SUB_AI, MTX_OP_ADD_AM, MTX_OP_ADD_MA, MTX_OP_ADDC_AM,
            MTX_OP_ADDC_MA, MTX_OP_ADDC_A, MTX_OP_ADDC_M, MTX_OP_SUB_AM, MTX_OP_SUB_MA};
        logic [7:0] av [10] = '{8'h7F, 8'h80, 8'h80, 8'h0F, 8'h7F, 8'hFE, 8'hFF, 8'h00, 8'h10, 8'h05};
        logic [7:0] mv [10] = '{8'h01, 8'h01, 8'h80, 8'hF0, 8'h00, 8'h01, 8'h00, 8'h0F, 8'h20, 8'h05};
        logic [11:0] e;
        for (int i = 0; i < 10; i++)
        begin
            issue(MTX_OP_LDI, 8'h00, 8'hFF);
            issue(MTX_OP_ADD_AI, 8'h00, 8'h01);  // Leaves carry set
            mtx_mem_model_inst.mem[8'h30] = mv[i];
            issue(MTX_OP_LDI, 8'h00, av[i]);
            issue(ops[i], 8'h30, mv[i]);
            case (ops[i])
                MTX_OP_ADDC_AM, MTX_OP_ADDC_MA: e = alu(av[i], mv[i], 1'b1, 1'b0);
                MTX_OP_ADDC_A: e = alu(av[i], 8'h00, 1'b1, 1'b0);
                MTX_OP_ADDC_M: e = alu(mv[i], 8'h00, 1'b1, 1'b0);
                MTX_OP_SUB_AI, MTX_OP_SUB_AM: e = alu(av[i], mv[i], 1'b0, 1'b1);
                MTX_OP_SUB_MA: e = alu(mv[i], av[i], 1'b0, 1'b1);
                default: e = alu(av[i], mv[i], 1'b0, 1'b0);
            endcase
            if (ops[i] inside {MTX_OP_ADD_MA, MTX_OP_ADDC_MA, MTX_OP_ADDC_M, MTX_OP_SUB_MA})
                chk(mtx_mem_model_inst.mem[8'h30], e[7:0]);
            else
                chk(working_register, e[7:0]);
            chk(flag_reg, {4'hF, e[11:8]});
        end
    endtask : t_arith
    task automatic t_counter;
        mtx_mem_model_inst.mem[8'h1F] = 8'hCD;
        mtx_mem_model_inst.mem[8'h20] = 8'hAB;
        issue(MTX_OP_CNT_WR, 8'h1F, 8'h00);
        chk(sixteen_bit_counter[7:0], 8'hCD);
        chk(sixteen_bit_counter[15:8], 8'hAB);
        issue(MTX_OP_CNT_RD, 8'h06, 8'h00);
        chk(mtx_mem_model_inst.mem[8'h06], 8'hCD);
        chk(mtx_mem_model_inst.mem[8'h07], 8'hAB);
        chk(flag_reg, 8'hF1);
        @(posedge sys_clk);
        op_code <= MTX_OP_CNT_WR;
        op_addr <= 8'h20;
        op_valid <= 1'b1;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        @(negedge sys_clk);
        chk(8'(addr_err), 8'h01);
        repeat (4) @(negedge sys_clk);
        chk(sixteen_bit_counter[15:8], 8'hAB);
    endtask : t_counter
    task automatic t_stack;
        mtx_mem_model_inst.mem[8'h08] = 8'h5B;
        mtx_mem_model_inst.mem[8'h09] = 8'h00;
        mtx_mem_model_inst.mem[8'h5B] = 8'hC3;
        issue(MTX_OP_IDX_LD, 8'h08, 8'h00);
        chk(working_register, 8'hC3);
        issue(MTX_OP_LDI, 8'h00, 8'hA5);
        issue(MTX_OP_IDX_ST, 8'h08, 8'h00);
        chk(8'(n), 8'h03);
        chk(mtx_mem_model_inst.mem[8'h5B], 8'hA5);
        @(posedge sys_clk);
        sp_wdata <= 8'h10;  // Kept even
        sp_we <= 1'b1;
        @(posedge sys_clk);
        sp_we <= 1'b0;
        issue(MTX_OP_LDI, 8'h00, 8'h7F);
        issue(MTX_OP_ADD_AI, 8'h00, 8'h01);
        issue(MTX_OP_SAVE, 8'h00, 8'h00);
        chk(mtx_mem_model_inst.mem[8'h11], 8'hFC);
        chk(stack_top_index, 8'h12);
        issue(MTX_OP_LDI, 8'h00, 8'hFF);
        issue(MTX_OP_ADD_AI, 8'h00, 8'h01);
        issue(MTX_OP_RESTORE, 8'h00, 8'h00);
        chk(stack_top_index, 8'h10);
        chk(working_register, 8'h80);
        chk(flag_reg, 8'hFC);
    endtask : t_stack
    // Hang guard, far beyond the few hundred cycles the sequence needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            test_done;
        end
    end
    initial
    begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = MTX_OP_NOP;
        op_addr = 8'h00;
        op_imm = 8'h00;
        sp_wdata = 8'h00;
        sp_we = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk(flag_reg, 8'hF0);
        chk(working_register, 8'h00);
        t_move;
        t_arith;
        t_counter;
        t_stack;
        test_done;
    end
endmodule : tb
